// ---- logic/acq_seq_pkg.sv ----
// shared constants, register map and types for the acquisition sequencer
package acq_seq_pkg;

   // clock and timebase rates
   localparam int CLK_HZ        = 100_000_000;
   localparam int TB_TOP_HZ     = 1_000_000;
   localparam int TB_TOP_DIV    = CLK_HZ / TB_TOP_HZ;
   localparam int TB_DECADE_DIV = 10;
   localparam int TB_COUNT      = 5;

   // result store
   localparam int FIFO_DEPTH_DEF = 512;

   // register offsets
   localparam logic [3:0] REG_COMMAND1 = 4'h0;
   localparam logic [3:0] REG_MUX_GAIN = 4'h1;
   localparam logic [3:0] REG_CLEAR    = 4'h2;
   localparam logic [3:0] REG_START    = 4'h3;
   localparam logic [3:0] REG_CTR_CMD  = 4'h4;
   localparam logic [3:0] REG_CTR_DATA = 4'h5;
   localparam logic [3:0] REG_STATUS   = 4'h6;
   localparam logic [3:0] REG_FIFO     = 4'h7;

   // command register 1 fields
   localparam int CMD1_ACQ_EN_BIT  = 0;
   localparam int CMD1_WIDE_BIT    = 1;
   localparam int CMD1_PRETRIG_BIT = 2;
   localparam int CMD1_EXTERNAL_CONVERT_N_BIT = 3;
   localparam logic [3:0] CMD1_RESET = 4'h0;

   // channel and gain fields
   localparam int MUX_GAIN_HI = 7;
   localparam int MUX_GAIN_LO = 6;
   localparam int MUX_CHAN_HI = 3;
   localparam logic [7:0] MUX_RESET = 8'h00;

   // status fields
   localparam int ST_AVAIL_BIT    = 13;
   localparam int ST_OVERFLOW_BIT = 12;
   localparam int ST_OVERRUN_BIT  = 11;
   localparam int ST_ACTIVE_BIT   = 10;

   // counter command word layout
   localparam logic [7:0] CC_PREFIX     = 8'hFF;
   localparam logic [2:0] CC_OP_SELECT  = 3'h0;
   localparam logic [2:0] CC_OP_ARM     = 3'h1;
   localparam logic [2:0] CC_OP_LOAD    = 3'h2;
   localparam logic [2:0] CC_OP_LOADARM = 3'h3;
   localparam logic [2:0] CC_OP_STEP    = 3'h7;
   localparam logic [1:0] CC_GRP_MODE   = 2'h0;
   localparam logic [1:0] CC_GRP_LOAD   = 2'h1;
   localparam logic [2:0] CC_FIRST_CTR  = 3'h3;
   localparam int CC_CTRS = 3;

   // interval counter mode source field
   localparam int MODE_SRC_LSB = 8;
   localparam logic [3:0] MODE_SRC_1M   = 4'hB;
   localparam logic [3:0] MODE_SRC_100K = 4'hC;
   localparam logic [3:0] MODE_SRC_10K  = 4'hD;
   localparam logic [3:0] MODE_SRC_1K   = 4'hE;
   localparam logic [3:0] MODE_SRC_100  = 4'hF;
   localparam logic [3:0] MODE_SRC_EXT5 = 4'h5;
   localparam logic [15:0] MODE_RESET   = 16'h0000;

   typedef enum logic [1:0] {
      ACQ_IDLE  = 2'b00,
      ACQ_ARMED = 2'b01,
      ACQ_RUN   = 2'b10,
      ACQ_HALT  = 2'b11
   } acq_state_e;

   typedef struct packed {
      logic load_wr;
      logic load;
      logic step;
      logic arm;
   } ctr_ctl_s;

endpackage : acq_seq_pkg

// ---- logic/tick_div.sv ----
// enable divider: one tick out per DIV ticks in
`timescale 1ns/1ps
module tick_div
   import acq_seq_pkg::*;
#(
   parameter int DIV = TB_DECADE_DIV
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // ticks
   input  wire logic tick_in,
   output logic      tick_out
);
   if (DIV < 2) begin : g_bad_div
      $error("tick_div: DIV must be at least 2");
   end

   localparam int W = $clog2(DIV);
   logic [W-1:0] cnt_q, cnt_d;

   assign tick_out = tick_in && (cnt_q == W'(DIV - 1));

   always_comb begin
      cnt_d = cnt_q;
      if (tick_out) begin
         cnt_d = '0;
      end else if (tick_in) begin
         cnt_d = cnt_q + W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : tick_div

// ---- logic/down_ctr_unit.sv ----
// reloading down counter with load register, arm and step commands
`timescale 1ns/1ps
module down_ctr_unit
   import acq_seq_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // command side
   input  ctr_ctl_s              ctl,
   input  wire logic [WIDTH-1:0] wdata,
   // counting side
   input  wire logic             gate,
   input  wire logic             tick,
   output logic                  terminal,
   output logic [WIDTH-1:0]      count
);
   if (WIDTH < 2) begin : g_bad_width
      $error("down_ctr_unit: WIDTH must be at least 2");
   end

   logic [WIDTH-1:0] load_q, load_d, count_q, count_d;
   logic             armed_q, armed_d;

   // load value 0 yields a full 2**WIDTH period through wrap
   assign terminal = armed_q && gate && tick && (count_q == WIDTH'(1));
   assign count    = count_q;

   always_comb begin
      load_d  = load_q;
      count_d = count_q;
      armed_d = armed_q;
      if (ctl.load_wr) begin
         load_d = wdata;
      end
      if (ctl.arm) begin
         armed_d = 1'b1;
      end
      if (ctl.load) begin
         count_d = load_q;
      end else if (ctl.step) begin
         count_d = count_q - WIDTH'(1);
      end else if (terminal) begin
         count_d = load_q;
      end else if (armed_q && gate && tick) begin
         count_d = count_q - WIDTH'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         load_q  <= '0;
         count_q <= '0;
         armed_q <= 1'b0;
      end else begin
         load_q  <= load_d;
         count_q <= count_d;
         armed_q <= armed_d;
      end
   end
endmodule : down_ctr_unit

// ---- logic/multi_conversion_acq_sequencer.sv ----
// paced multi-conversion acquisition sequencer with sample counter and result store
//
// Functional notes
// - clear write drops error flags and results
// - interval counter or external pin paces conversions
// - software write or start pin starts sequence
// - posttrigger: count every conversion, stop at zero
// - pretrigger: hold count until stop trigger rises
// - counters reload at end, retrigger without reprogramming
// - gain bits 7..6, channel bits 3..0
// - channel and gain setting persists across conversions
// - interval pulse every N timebase periods, 2..65536
// - timebases 1M..100Hz or external source five
// - mode words 8B25..8F25, 8525 pick timebase
// - interval 65536 is stored as zero
// - arm command, then pulses once triggered
// - sample counter halts interval counter at count
// - wide counts cascade fourth and fifth counters
// - result store overflow raises flag and stops
// - conversion during conversion raises overrun, stops
// - trigger acts only with acquisition enable set
// - wide select picks one or two counters
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module multi_conversion_acq_sequencer
   import acq_seq_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RESET,
   // register port
   input  wire logic [3:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [15:0] RDATA,
   // trigger and timing pins
   input  wire logic        EXTERNAL_CONVERT_N,
   input  wire logic        START_TRIGGER_N,
   input  wire logic        STOP_TRIGGER_IN,
   input  wire logic        EXTERNAL_COUNT_INPUT_FIVE,
   // converter side
   input  wire logic        ADC_DONE,
   input  wire logic [11:0] ADC_DATA,
   output logic             CONVERT_PULSE,
   output logic [3:0]       CHANNEL,
   output logic [1:0]       GAIN,
   output logic             ACQ_ACTIVE
);
   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two of at least 2");
   end

   localparam int AW = $clog2(FIFO_DEPTH);

   // register decode
   logic wr_cmd1, wr_mux, wr_clear, wr_start, wr_ccmd, wr_cdata, cc_valid;
   logic [2:0] cc_op;
   assign wr_cmd1  = WR && (ADDR == REG_COMMAND1);
   assign wr_mux   = WR && (ADDR == REG_MUX_GAIN);
   assign wr_clear = WR && (ADDR == REG_CLEAR);
   assign wr_start = WR && (ADDR == REG_START);
   assign wr_ccmd  = WR && (ADDR == REG_CTR_CMD);
   assign wr_cdata = WR && (ADDR == REG_CTR_DATA);
   assign cc_valid = wr_ccmd && (WDATA[15:8] == CC_PREFIX);
   assign cc_op    = WDATA[7:5];

   // configuration registers
   logic [3:0]  cmd1_q, cmd1_d;
   logic [7:0]  mux_q, mux_d;
   logic [4:0]  sel_q, sel_d;
   logic [15:0] mode3_q, mode3_d;
   ctr_ctl_s    ctl [CC_CTRS];

   always_comb begin
      cmd1_d  = cmd1_q;
      mux_d   = mux_q;
      sel_d   = sel_q;
      mode3_d = mode3_q;
      if (wr_cmd1) begin
         cmd1_d = WDATA[3:0];
      end
      if (wr_mux) begin
         mux_d = WDATA[7:0];
      end
      if (cc_valid && cc_op == CC_OP_SELECT) begin
         sel_d = WDATA[4:0];
      end
      if (wr_cdata && sel_q == {CC_GRP_MODE, CC_FIRST_CTR}) begin
         mode3_d = WDATA;
      end
      for (int k = 0; k < CC_CTRS; k++) begin
         ctl[k].load_wr = wr_cdata && sel_q == {CC_GRP_LOAD, CC_FIRST_CTR + 3'(k)};
         ctl[k].load    = cc_valid && (cc_op == CC_OP_LOAD || cc_op == CC_OP_LOADARM) && WDATA[k + 2];
         ctl[k].arm     = cc_valid && (cc_op == CC_OP_ARM || cc_op == CC_OP_LOADARM) && WDATA[k + 2];
         ctl[k].step    = cc_valid && cc_op == CC_OP_STEP && WDATA[2:0] == CC_FIRST_CTR + 3'(k);
      end
   end

   // mux register only changes on its own write
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         cmd1_q  <= CMD1_RESET;
         mux_q   <= MUX_RESET;
         sel_q   <= '0;
         mode3_q <= MODE_RESET;
      end else begin
         cmd1_q  <= cmd1_d;
         mux_q   <= mux_d;
         sel_q   <= sel_d;
         mode3_q <= mode3_d;
      end
   end

   // timebase chain
   logic [TB_COUNT-1:0] tb_tick;
   tick_div #(.DIV(TB_TOP_DIV)) u_tb_top (
      .clk      (CLK_SYS),
      .rst      (RESET),
      .tick_in  (1'b1),
      .tick_out (tb_tick[0])
   );
   for (genvar i = 1; i < TB_COUNT; i++) begin : g_decade
      tick_div #(.DIV(TB_DECADE_DIV)) u_tb (
         .clk      (CLK_SYS),
         .rst      (RESET),
         .tick_in  (tb_tick[i - 1]),
         .tick_out (tb_tick[i])
      );
   end

   // edge history and acquisition state
   acq_state_e state_q, state_d;
   logic src5_prev_q, start_prev_q, ext_prev_q, stop_prev_q;
   logic busy_q, busy_d, overflow_q, overflow_d, overrun_q, overrun_d;
   logic stop_seen_q, stop_seen_d, conv_q;
   logic run, acq_en, wide, pretrig, extsel, trigger, interval_tick;
   logic conv, term3, term4, term5, done, push, full, empty, pop;
   logic overflow_set, overrun_set, err;
   logic [15:0] count4;

   assign run     = (state_q == ACQ_RUN);
   assign acq_en  = cmd1_q[CMD1_ACQ_EN_BIT];
   assign wide    = cmd1_q[CMD1_WIDE_BIT];
   assign pretrig = cmd1_q[CMD1_PRETRIG_BIT];
   assign extsel  = cmd1_q[CMD1_EXTERNAL_CONVERT_N_BIT];
   assign trigger = wr_start || (start_prev_q && !START_TRIGGER_N);

   always_comb begin
      case (mode3_q[MODE_SRC_LSB +: 4])
         MODE_SRC_1M:   interval_tick = tb_tick[0];
         MODE_SRC_100K: interval_tick = tb_tick[1];
         MODE_SRC_10K:  interval_tick = tb_tick[2];
         MODE_SRC_1K:   interval_tick = tb_tick[3];
         MODE_SRC_100:  interval_tick = tb_tick[4];
         MODE_SRC_EXT5: interval_tick = EXTERNAL_COUNT_INPUT_FIVE && !src5_prev_q;
         default:       interval_tick = 1'b0;
      endcase
   end

   // interval counter stops as soon as the run ends
   down_ctr_unit u_interval (
      .clk      (CLK_SYS),
      .rst      (RESET),
      .ctl      (ctl[0]),
      .wdata    (WDATA),
      .gate     (run && !extsel),
      .tick     (interval_tick),
      .terminal (term3),
      .count    ()
   );
   assign conv = run && (extsel ? (ext_prev_q && !EXTERNAL_CONVERT_N) : term3);

   down_ctr_unit u_sample_lo (
      .clk      (CLK_SYS),
      .rst      (RESET),
      .ctl      (ctl[1]),
      .wdata    (WDATA),
      .gate     (run && (!pretrig || stop_seen_q)),
      .tick     (conv),
      .terminal (term4),
      .count    (count4)
   );
   down_ctr_unit u_sample_hi (
      .clk      (CLK_SYS),
      .rst      (RESET),
      .ctl      (ctl[2]),
      .wdata    (WDATA),
      .gate     (run && wide),
      .tick     (term4),
      .terminal (term5),
      .count    ()
   );
   assign done = wide ? term5 : term4;

   // result store
   logic [11:0]  mem [FIFO_DEPTH];
   logic [AW:0]  wptr_q, wptr_d, rptr_q, rptr_d, fill;
   logic [15:0]  rdata_q, rdata_d, status_w;
   logic         push_ok;

   assign fill         = wptr_q - rptr_q;
   assign full         = (fill == (AW + 1)'(FIFO_DEPTH));
   assign empty        = (fill == '0);
   assign push         = ADC_DONE && busy_q;
   assign push_ok      = push && (wr_clear || !full);
   assign pop          = RD && (ADDR == REG_FIFO) && !empty && !wr_clear;
   assign overflow_set = push && full && !wr_clear;
   assign overrun_set  = conv && busy_q && !ADC_DONE;
   assign err          = overflow_set || overrun_set;

   always_comb begin
      busy_d      = conv || (busy_q && !ADC_DONE);
      overflow_d  = overflow_set || (overflow_q && !wr_clear);
      overrun_d   = overrun_set || (overrun_q && !wr_clear);
      stop_seen_d = stop_seen_q;
      if (run && STOP_TRIGGER_IN && !stop_prev_q) begin
         stop_seen_d = 1'b1;
      end else if (state_q == ACQ_ARMED) begin
         stop_seen_d = 1'b0;
      end
      if (wr_clear) begin
         wptr_d = push_ok ? (AW + 1)'(1) : '0;
         rptr_d = '0;
      end else begin
         wptr_d = wptr_q + (AW + 1)'(push_ok);
         rptr_d = rptr_q + (AW + 1)'(pop);
      end
      state_d = state_q;
      case (state_q)
         ACQ_IDLE:  if (acq_en) state_d = ACQ_ARMED;
         ACQ_ARMED: begin
            if (!acq_en) begin
               state_d = ACQ_IDLE;
            end else if (trigger) begin
               state_d = ACQ_RUN;
            end
         end
         ACQ_RUN: begin
            if (err) begin
               state_d = ACQ_HALT;
            end else if (!acq_en) begin
               state_d = ACQ_IDLE;
            end else if (done) begin
               state_d = ACQ_ARMED;
            end
         end
         ACQ_HALT:  if (wr_clear) state_d = acq_en ? ACQ_ARMED : ACQ_IDLE;
         default:   state_d = ACQ_IDLE;
      endcase
   end

   always_comb begin
      status_w                  = 16'h0000;
      status_w[ST_AVAIL_BIT]    = !empty;
      status_w[ST_OVERFLOW_BIT] = overflow_q;
      status_w[ST_OVERRUN_BIT]  = overrun_q;
      status_w[ST_ACTIVE_BIT]   = run;
      rdata_d                   = 16'h0000;
      if (RD) begin
         case (ADDR)
            REG_COMMAND1: rdata_d = {12'h000, cmd1_q};
            REG_MUX_GAIN: rdata_d = {8'h00, mux_q[MUX_GAIN_HI:MUX_GAIN_LO], 2'b00, mux_q[MUX_CHAN_HI:0]};
            REG_STATUS:   rdata_d = status_w;
            REG_FIFO:     rdata_d = empty ? 16'h0000 : {4'h0, mem[rptr_q[AW-1:0]]};
            default:      rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (push_ok) begin
         mem[wr_clear ? '0 : wptr_q[AW-1:0]] <= ADC_DATA;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         state_q      <= ACQ_IDLE;
         src5_prev_q  <= 1'b0;
         start_prev_q <= 1'b1;
         ext_prev_q   <= 1'b1;
         stop_prev_q  <= 1'b0;
         busy_q       <= 1'b0;
         overflow_q   <= 1'b0;
         overrun_q    <= 1'b0;
         stop_seen_q  <= 1'b0;
         conv_q       <= 1'b0;
         wptr_q       <= '0;
         rptr_q       <= '0;
         rdata_q      <= 16'h0000;
      end else begin
         state_q      <= state_d;
         src5_prev_q  <= EXTERNAL_COUNT_INPUT_FIVE;
         start_prev_q <= START_TRIGGER_N;
         ext_prev_q   <= EXTERNAL_CONVERT_N;
         stop_prev_q  <= STOP_TRIGGER_IN;
         busy_q       <= busy_d;
         overflow_q   <= overflow_d;
         overrun_q    <= overrun_d;
         stop_seen_q  <= stop_seen_d;
         conv_q       <= conv;
         wptr_q       <= wptr_d;
         rptr_q       <= rptr_d;
         rdata_q      <= rdata_d;
      end
   end

   assign RDATA         = rdata_q;
   assign CONVERT_PULSE = conv_q;
   assign CHANNEL       = mux_q[MUX_CHAN_HI:0];
   assign GAIN          = mux_q[MUX_GAIN_HI:MUX_GAIN_LO];
   assign ACQ_ACTIVE    = run;

   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   sequence clear_no_set_s;
      wr_clear && !overflow_set && !overrun_set;
   endsequence
   sequence run_stops_s;
      run && done && !err && acq_en;
   endsequence

   clear_flags_a: assert property (clear_no_set_s |=> !overflow_q && !overrun_q)
      else $error("error flags survive a clear");
   clear_empty_a: assert property (wr_clear && !push |=> empty)
      else $error("results survive a clear");
   conv_cause_a: assert property (CONVERT_PULSE |-> $past(run) && ($past(term3) || $past(extsel)))
      else $error("conversion pulse without pacing source");
   start_cause_a: assert property (state_q == ACQ_ARMED && !trigger |=> state_q != ACQ_RUN)
      else $error("run started without trigger");
   rearm_end_a: assert property (run_stops_s |=> state_q == ACQ_ARMED ##1 !CONVERT_PULSE)
      else $error("run did not end at terminal count");
   pre_hold_a: assert property (run && pretrig && !stop_seen_q && !ctl[1].load && !ctl[1].step
                                |=> $stable(count4))
      else $error("sample count moved before stop trigger");
   mux_hold_a: assert property (!wr_mux |=> $stable(CHANNEL) && $stable(GAIN))
      else $error("channel or gain changed without write");
   overrun_stop_a: assert property (run && overrun_set |=> overrun_q && state_q == ACQ_HALT)
      else $error("overrun did not stop acquisition");
   overflow_stop_a: assert property (run && overflow_set |=> overflow_q && state_q == ACQ_HALT)
      else $error("overflow did not stop acquisition");
   enable_gate_a: assert property (!acq_en && !run |=> !run)
      else $error("run began while acquisition disabled");

endmodule : multi_conversion_acq_sequencer

// ---- bench/adc_model.sv ----
// converter model: answers a convert pulse after a set latency; a pulse while busy restarts the latency
`timescale 1ns/1ps
module adc_model (
   // clock
   input  wire logic       clk,
   // converter side
   input  wire logic       start,
   input  wire logic [9:0] lat,
   output logic            done,
   output logic [11:0]     data
);
   logic [9:0]  cnt_q;
   logic [11:0] seq_q;
   logic        busy_q;

   initial begin
      cnt_q = 10'h000;
      seq_q = 12'hA00;
      busy_q = 1'b0;
      done = 1'b0;
      data = 12'h5A5;
   end

   // data is only valid with done; otherwise it keeps changing
   always @(posedge clk) begin
      done <= 1'b0;
      data <= ~data;
      if (start) begin
         busy_q <= 1'b1;
         cnt_q <= lat;
      end else if (busy_q && cnt_q == 10'h001) begin
         busy_q <= 1'b0;
         done <= 1'b1;
         data <= seq_q;
         seq_q <= seq_q + 12'h001;
      end else if (busy_q)
         cnt_q <= cnt_q - 10'h001;
   end
endmodule : adc_model

// ---- bench/multi_conversion_acq_sequencer_tb.sv ----
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
module multi_conversion_acq_sequencer_tb;
   import acq_seq_pkg::*;
   logic        clk, rst, wr, rd, ext_conv_n, start_n, stop_in, src5;
   logic        adc_done, conv, active;
   logic [3:0]  addr, channel;
   logic [1:0]  gain;
   logic [15:0] wdata, rdata, d;
   logic [11:0] adc_data;
   logic [9:0]  lat;
   int          fails, tests_run, cyc, last, gap, conv_cnt, done_cnt, c0, base;
   logic [15:0] modes [4] = '{16'h8B25, 16'h8C25, 16'h8D25, 16'h8525};
   int          gaps [4] = '{200, 2000, 20000, 12};

   multi_conversion_acq_sequencer #(.FIFO_DEPTH(8)) u_dut (
      .CLK_SYS(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .EXTERNAL_CONVERT_N(ext_conv_n), .START_TRIGGER_N(start_n), .STOP_TRIGGER_IN(stop_in),
      .EXTERNAL_COUNT_INPUT_FIVE(src5), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
      .CONVERT_PULSE(conv), .CHANNEL(channel), .GAIN(gain), .ACQ_ACTIVE(active));

   adc_model u_adc (.clk(clk), .start(conv), .lat(lat), .done(adc_done), .data(adc_data));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   // monitor, external timebase and run limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 3 == 0)
         src5 <= ~src5;
      if (conv === 1'b1) begin
         conv_cnt <= conv_cnt + 1;
         gap <= cyc - last;
         last <= cyc;
      end
      if (adc_done === 1'b1)
         done_cnt <= done_cnt + 1;
      if (cyc == 90000) begin
         fails++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wreg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   task automatic rreg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg

   task automatic wait_act(input logic v, input int lim);
      for (int i = 0; i < lim && active !== v; i++) begin
         @(posedge clk);
         #1;
      end
   endtask : wait_act

   task automatic prog_interval(input logic [15:0] mode, input logic [15:0] n);
      wreg(REG_CTR_CMD, 16'hFF03);
      wreg(REG_CTR_DATA, mode);
      wreg(REG_CTR_CMD, 16'hFF0B);
      wreg(REG_CTR_DATA, 16'h0002);
      wreg(REG_CTR_CMD, 16'hFF44);
      wreg(REG_CTR_CMD, 16'hFFF3);
      wreg(REG_CTR_DATA, n);
      wreg(REG_CTR_CMD, 16'hFF24);
   endtask : prog_interval

   task automatic prog_samples(input logic [15:0] n);
      wreg(REG_CTR_CMD, 16'hFF04);
      wreg(REG_CTR_DATA, 16'h1025);
      wreg(REG_CTR_CMD, 16'hFF0C);
      wreg(REG_CTR_DATA, n);
      wreg(REG_CTR_CMD, 16'hFF48);
      wreg(REG_CTR_CMD, 16'hFF28);
   endtask : prog_samples

   // clear, enable, then trigger by write or by pin
   task automatic go(input logic [3:0] cmd, input bit pin);
      wreg(REG_CLEAR, 16'h0000);
      wreg(REG_COMMAND1, {12'h000, cmd});
      c0 = conv_cnt;
      base = done_cnt;
      if (pin) begin
         @(posedge clk);
         start_n <= 1'b0;
         @(posedge clk);
         start_n <= 1'b1;
      end else
         wreg(REG_START, 16'h0000);
      wait_act(1'b1, 5);
      chk("active", 16'h0001, {15'h0000, active});
   endtask : go

   task automatic fin(input int lim, input int n);
      wait_act(1'b0, lim);
      repeat (40) @(posedge clk);
      chk("conversions", 16'(n), 16'(conv_cnt - c0));
   endtask : fin

   task automatic drain(input int n);
      for (int i = 0; i < n; i++) begin
         rreg(REG_FIFO);
         chk("fifo", 16'h0A00 + 16'(base + i), d);
      end
      rreg(REG_STATUS);
      chk("available", 16'h0000, d & 16'h2000);
   endtask : drain

   initial begin
      {rst, wr, rd, stop_in, src5} = 5'b10000;
      {ext_conv_n, start_n} = 2'b11;
      {addr, wdata, lat} = {4'h0, 16'h0000, 10'd20};
      {cyc, last, gap, conv_cnt, done_cnt, fails, tests_run} = '0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rreg(REG_STATUS);
      chk("status reset", 16'h0000, d);
      rreg(REG_MUX_GAIN);
      chk("mux reset", 16'h0000, d);
      wreg(REG_MUX_GAIN, 16'hFFCA);
      rreg(REG_MUX_GAIN);
      chk("mux", 16'h00CA, d);
      rreg(4'h8);
      chk("unmapped", 16'h0000, d);
      $display("test registers done");
      prog_interval(16'h8B25, 16'h0002);
      prog_samples(16'h0003);
      go(4'h1, 1'b0);
      fin(2000, 3);
      drain(3);
      go(4'h1, 1'b1);
      fin(2000, 3);
      drain(3);
      chk("pins", 16'h00CA, {8'h00, gain, 2'b00, channel});
      wreg(REG_COMMAND1, 16'h0000);
      c0 = conv_cnt;
      wreg(REG_START, 16'h0000);
      repeat (300) @(posedge clk);
      chk("disabled", 16'h0000, 16'(conv_cnt - c0) | {15'h0000, active});
      $display("test posttrigger done");
      // short latency keeps the 12-cycle external spacing clear of overrun
      lat <= 10'd5;
      foreach (modes[k]) begin
         prog_interval(modes[k], 16'h0002);
         prog_samples(16'h0002);
         go(4'h1, 1'b0);
         fin(50000, 2);
         chk("gap", 16'(gaps[k]), 16'(gap));
         rreg(REG_STATUS);
         chk("timebase errors", 16'h0000, d & 16'h1800);
      end
      // slow bases give no pulse within a short window
      for (int j = 0; j < 2; j++) begin
         prog_interval(16'h8E25 + 16'(j * 256), 16'h0002);
         prog_samples(16'h0002);
         go(4'h1, 1'b0);
         repeat (300) @(posedge clk);
         chk("slow base", 16'h0000, 16'(conv_cnt - c0));
         wreg(REG_COMMAND1, 16'h0000);
      end
      lat <= 10'd20;
      $display("test timebases done");
      prog_interval(16'h8B25, 16'h0002);
      prog_samples(16'h0002);
      wreg(REG_CTR_CMD, 16'hFF05);
      wreg(REG_CTR_DATA, 16'h0025);
      wreg(REG_CTR_CMD, 16'hFF0D);
      wreg(REG_CTR_DATA, 16'h0002);
      wreg(REG_CTR_CMD, 16'hFF70);
      go(4'h3, 1'b0);
      fin(3000, 4);
      $display("test wide done");
      prog_samples(16'h0002);
      go(4'h5, 1'b0);
      repeat (1000) @(posedge clk);
      chk("pre hold", 16'h0001, {15'h0000, active});
      stop_in <= 1'b1;
      c0 = conv_cnt;
      fin(2000, 2);
      stop_in <= 1'b0;
      prog_samples(16'h0003);
      go(4'h9, 1'b0);
      repeat (3) begin
         repeat (50) @(posedge clk);
         ext_conv_n <= 1'b0;
         @(posedge clk);
         ext_conv_n <= 1'b1;
      end
      fin(100, 3);
      drain(3);
      $display("test pretrigger and external done");
      lat <= 10'd300;
      prog_samples(16'h0005);
      go(4'h1, 1'b0);
      fin(1000, 2);
      repeat (600) @(posedge clk);
      rreg(REG_STATUS);
      chk("overrun", 16'h0800, d & 16'h1C00);
      wreg(REG_CLEAR, 16'h0000);
      rreg(REG_STATUS);
      chk("cleared", 16'h0000, d);
      lat <= 10'd20;
      prog_samples(16'h000C);
      go(4'h1, 1'b0);
      fin(5000, 9);
      rreg(REG_STATUS);
      chk("overflow", 16'h3000, d & 16'h3C00);
      drain(8);
      wreg(REG_CLEAR, 16'h0000);
      rreg(REG_STATUS);
      chk("cleared", 16'h0000, d);
      rreg(REG_FIFO);
      chk("empty read", 16'h0000, d);
      $display("test errors done");
      complete_run();
   end
endmodule : multi_conversion_acq_sequencer_tb
